/* lprs_port.sv */
// Purpose: APB register port for controller reset and self-test
// Assumes: APB4 slave, pclk 25 MHz, units answer by level handshakes
// Notes: pready is always high; unmapped addresses give pslverr
`include "lprs_cfg.svh"

module lprs_port
  import lprs_pkg::*;
#(
  parameter int RST_HOLD = `LPRS_RST_HOLD
)
(
  input wire logic pclk, // controller clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [15:0] gptr, // general pointer to units
  output logic unit_idle_req, // ask both units to go idle
  input wire logic cu_idle, // command unit is idle
  input wire logic ru_idle, // receive unit is idle
  output logic test_start, // self-test running request
  input wire logic test_done, // self-test finished
  input wire lprs_result_t test_result, // self-test outcome
  output logic mem_req, // result write request
  output lprs_memwr_t mem_wr, // result write address and data
  input wire logic mem_ack, // result write accepted
  output logic ctrl_reset // full controller reset, held
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the hold counter is eight bits wide
  generate
    if (RST_HOLD < 1 || RST_HOLD > 255)
    begin : g_chk
      $error("RST_HOLD must be 1..255");
    end
    // selector is four bits with the pointer field right above it
    if ((`LPRS_FN_MSB - `LPRS_FN_LSB) != 3 ||
        `LPRS_PTR_LSB != (`LPRS_FN_MSB + 1))
    begin : g_fld
      $error("function and pointer fields must abut");
    end
  endgenerate

  localparam logic [7:0] HOLD_LAST = 8'(RST_HOLD - 1);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // byte lanes merged so word, half-word and byte writes look alike
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic fn_valid(input logic [3:0] fn);
    return (fn == `LPRS_FN_SWRST) || (fn == `LPRS_FN_TEST) ||
           (fn == `LPRS_FN_SELRST);
  endfunction

  function automatic logic [3:0] fn_of(input logic [31:0] v);
    return v[`LPRS_FN_MSB:`LPRS_FN_LSB];
  endfunction

  // reserved positions stay zero; the overall bit is any unit failing
  function automatic logic [31:0] pack_result(input lprs_result_t r);
    logic [31:0] w;
    w = 32'h00000000;
    w[`LPRS_RES_GEN] = |r;
    w[`LPRS_RES_DIAG] = r.diag_fail;
    w[`LPRS_RES_REG] = r.reg_fail;
    w[`LPRS_RES_ROM] = r.rom_fail;
    return w;
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic hit_gptr;
  logic hit_port;
  logic wr_gptr;
  logic wr_port;
  logic cmd_wr;
  logic [31:0] port_new;
  logic [3:0] fn_new;

  assign acc = psel && penable;
  assign hit_gptr = (paddr == `LPRS_OFS_GPTR);
  assign hit_port = (paddr == `LPRS_OFS_PORT);
  assign wr_gptr = acc && pwrite && hit_gptr;
  assign wr_port = acc && pwrite && hit_port;
  // zero wait states: every access ends in its first access cycle
  assign pready = 1'h1;
  assign pslverr = acc && !(hit_gptr || hit_port);

  // ---------------------------------------------------------------
  // registers and sequencer
  // ---------------------------------------------------------------
  logic [31:0] gptr_q, gptr_d;
  logic [31:0] port_q, port_d;
  lprs_state_t st_q, st_d;
  logic [7:0] hold_q, hold_d;
  logic [31:0] res_q, res_d;
  logic [31:0] rd_q, rd_d;

  assign port_new = lane_merge(port_q, pwdata, pstrb);
  assign fn_new = fn_of(port_new);
  // port writes while a command runs are dropped; no new command starts
  assign cmd_wr = wr_port && pstrb[`LPRS_CMD_LANE] &&
                  (st_q == ST_IDLE) && fn_valid(fn_new);

  always_comb
  begin
    gptr_d = gptr_q;
    port_d = port_q;
    st_d = st_q;
    hold_d = hold_q;
    res_d = res_q;
    if (wr_gptr)
    begin
      gptr_d = lane_merge(gptr_q, pwdata, pstrb) &
               `LPRS_GPTR_MASK;
    end
    if (wr_port && st_q == ST_IDLE)
    begin
      port_d = port_new;
    end
    if (cmd_wr)
    begin
      case (fn_new)
        `LPRS_FN_SWRST:
        begin
          st_d = ST_FRST;
          hold_d = 8'h00;
        end
        `LPRS_FN_TEST: st_d = ST_SEL;
        `LPRS_FN_SELRST: st_d = ST_SEL;
        default: st_d = st_q;
      endcase
    end
    case (st_q)
      ST_IDLE:
      begin
      end
      ST_SEL:
      begin
        // pointer and unit settings stay untouched here
        // no timer: a unit that never idles keeps the port busy
        if (cu_idle && ru_idle)
        begin
          if (fn_of(port_q) == `LPRS_FN_TEST)
          begin
            st_d = ST_TEST;
          end
          else
          begin
            port_d = `LPRS_PORT_RST;
            st_d = ST_IDLE;
          end
        end
      end
      ST_TEST:
      begin
        if (test_done)
        begin
          // latched once so the word stands unchanged until the ack
          res_d = pack_result(test_result);
          st_d = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (mem_ack)
        begin
          st_d = ST_FRST;
          hold_d = 8'h00;
        end
      end
      ST_FRST:
      begin
        // the whole port returns to defaults when the hold ends
        // port writes are dropped while the hold runs
        if (hold_q == HOLD_LAST)
        begin
          st_d = ST_IDLE;
          gptr_d = `LPRS_GPTR_RST;
          port_d = `LPRS_PORT_RST;
          res_d = 32'h00000000;
          hold_d = 8'h00;
        end
        else
        begin
          hold_d = hold_q + 8'h01;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_d = 32'h00000000;
    if (hit_gptr)
    begin
      rd_d = gptr_q;
    end
    else if (hit_port)
    begin
      rd_d = port_q;
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gptr_q <= `LPRS_GPTR_RST;
      port_q <= `LPRS_PORT_RST;
      st_q <= ST_IDLE;
      hold_q <= 8'h00;
      res_q <= 32'h00000000;
      rd_q <= 32'h00000000;
    end
    else
    begin
      gptr_q <= gptr_d;
      port_q <= port_d;
      st_q <= st_d;
      hold_q <= hold_d;
      res_q <= res_d;
      rd_q <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // read data registered in setup so it is stable in access phase
  assign prdata = rd_q;
  assign gptr = gptr_q[15:0];

  // ---------------------------------------------------------------
  // unit, self-test and memory handshakes
  // ---------------------------------------------------------------
  assign unit_idle_req = (st_q == ST_SEL);
  assign test_start = (st_q == ST_TEST);
  assign mem_req = (st_q == ST_WRITE);
  // result goes to the 16-byte aligned pointer, low nibble forced
  assign mem_wr.addr = {port_q[`LPRS_PTR_MSB:`LPRS_PTR_LSB],
                        4'h0};
  assign mem_wr.data = res_q;
  // no status bit or strobe marks test end
  // a level for the whole hold so every unit sees it
  assign ctrl_reset = (st_q == ST_FRST);

endmodule

/* lprs_cfg.svh */
// Purpose: offsets, fields and counts of the reset/self-test port
// Assumes: 32-bit APB, byte addresses
// Notes: definitions only
`ifndef LPRS_CFG_SVH
`define LPRS_CFG_SVH
`define LPRS_OFS_GPTR 12'h004
`define LPRS_OFS_PORT 12'h008
`define LPRS_GPTR_RST 32'h00000000
`define LPRS_PORT_RST 32'h00000000
`define LPRS_GPTR_MASK 32'h0000FFFF
`define LPRS_FN_LSB 0
`define LPRS_FN_MSB 3
`define LPRS_PTR_LSB 4
`define LPRS_PTR_MSB 31
`define LPRS_CMD_LANE 3
`define LPRS_FN_SWRST 4'h0
`define LPRS_FN_TEST 4'h1
`define LPRS_FN_SELRST 4'h2
`define LPRS_RES_GEN 12
`define LPRS_RES_DIAG 5
`define LPRS_RES_REG 3
`define LPRS_RES_ROM 2
`define LPRS_RST_HOLD 4
`endif

/* lprs_pkg.sv */
// Purpose: shared types of the reset/self-test port
// Assumes: constants live in lprs_cfg.svh
// Notes: none
package lprs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_TEST,
    ST_WRITE,
    ST_FRST
  } lprs_state_t;
  // outcome of the unit self-tests, 1 = fail
  typedef struct packed {
    logic diag_fail;
    logic reg_fail;
    logic rom_fail;
  } lprs_result_t;
  // one host-memory word write
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } lprs_memwr_t;
endpackage

/* lprs_unit_model.sv */
// Purpose: stand-in for the units, self-test engine and memory
// Assumes: every request is answered four cycles after it changes, ru_idle one cycle earlier
// Notes: fail pattern set by the bench
module lprs_unit_model
  import lprs_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic unit_idle_req, // go idle
  input wire logic test_start, // test runs
  input wire logic mem_req, // result write
  input wire lprs_result_t fail, // outcome to report
  output logic cu_idle, // cmd unit idle
  output logic ru_idle, // rcv unit idle
  output logic test_done, // test over
  output lprs_result_t test_result, // outcome
  output logic mem_ack // write taken
);
  timeunit 1ns / 1ns;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] req_q;
  wire [2:0] req = {unit_idle_req, test_start, mem_req};
  // count only a settled request, so a stale count never answers
  // in the cycle a request appears; saturate so it answers once
  wire same = req == req_q;
  wire rdy = same && cnt_q == 4'h3;
  always_comb
    cnt_d = !same ? 4'h0 : (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {cnt_q, req_q} <= 7'h00;
    else
      {cnt_q, req_q} <= {cnt_d, req};
  end
  // ru idles first so a design that waits on ru_idle only is caught
  assign cu_idle = unit_idle_req && rdy;
  assign ru_idle = unit_idle_req && same && cnt_q >= 4'h2;
  assign test_done = test_start && rdy;
  assign test_result = fail;
  assign mem_ack = mem_req && rdy;
endmodule

/* lprs_port_asserts.sv */
// Purpose: temporal checks on the port block
// Assumes: whole-word strobes for command checks
// Notes: bound after the module
module lprs_port_asserts
  import lprs_pkg::*;
#(
  parameter int RST_HOLD = 4
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [3:0] pstrb, // apb
  input wire logic pslverr, // apb
  input wire logic [15:0] gptr, // pointer
  input wire logic unit_idle_req, // units
  input wire logic cu_idle, // units
  input wire logic ru_idle, // units
  input wire logic test_start, // test
  input wire logic test_done, // test
  input wire logic mem_req, // memory
  input wire lprs_memwr_t mem_wr, // memory
  input wire logic mem_ack, // memory
  input wire logic ctrl_reset // reset out
);
  timeunit 1ns / 1ns;
  wire wr = psel && penable && pwrite;
  wire pw = wr && paddr == 12'h008 && pstrb == 4'hF;
  wire idl = !(unit_idle_req || test_start || mem_req || ctrl_reset);
  // cycles the current ctrl_reset pulse has stood so far
  int rst_len;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_len <= 0;
    else
      rst_len <= ctrl_reset ? rst_len + 1 : 0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_err; psel && penable && !(paddr inside {12'h004, 12'h008})
    |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no pslverr");
  property p_gptr; wr && paddr == 12'h004 && pstrb == 4'hF
    |=> {16'h0000, gptr} == ($past(pwdata) & 32'h0000FFFF); endproperty
  a_gptr: assert property (p_gptr) else $error("gptr");
  property p_sel; pw && idl && pwdata[3:0] inside {4'h1, 4'h2}
    |=> unit_idle_req; endproperty
  a_sel: assert property (p_sel) else $error("no idle req");
  property p_full; pw && idl && pwdata[3:0] == 4'h0 |=> ctrl_reset;
  endproperty
  a_full: assert property (p_full) else $error("no full reset");
  property p_resv; wr && paddr == 12'h008 && idl && (!pstrb[3]
    || (pstrb[0] && pwdata[3:0] > 4'h2)) |=> idl; endproperty
  a_resv: assert property (p_resv) else $error("acted");
  property p_done; unit_idle_req && cu_idle && ru_idle |=> !unit_idle_req;
  endproperty
  a_done: assert property (p_done) else $error("sel hang");
  property p_test; test_start && test_done |=> mem_req && !test_start;
  endproperty
  a_test: assert property (p_test) else $error("no store");
  property p_word; mem_req |-> mem_wr.addr[3:0] == 4'h0 &&
    (mem_wr.data & 32'hFFFFEFD3) == 32'h0 &&
    mem_wr.data[12] == |mem_wr.data[5:2]; endproperty
  a_word: assert property (p_word) else $error("word");
  property p_rst; mem_req && mem_ack |=> ctrl_reset && !mem_req;
  endproperty
  a_rst: assert property (p_rst) else $error("no reset");
  property p_hold; $fell(ctrl_reset) |-> rst_len == RST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("hold length");
endmodule
bind lprs_port lprs_port_asserts #(.RST_HOLD(RST_HOLD)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .pslverr(pslverr),
  .gptr(gptr),
  .unit_idle_req(unit_idle_req),
  .cu_idle(cu_idle),
  .ru_idle(ru_idle),
  .test_start(test_start),
  .test_done(test_done),
  .mem_req(mem_req),
  .mem_wr(mem_wr),
  .mem_ack(mem_ack),
  .ctrl_reset(ctrl_reset)
);

/* test_lprs_port.sv */
// Purpose: register-level bench for the port block
// Assumes: zero-wait apb slave
// Notes: short reset hold
module test_lprs_port
  import lprs_pkg::*;
;
  timeunit 1ns / 1ns;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, rd_e, pready, pslverr, unit_idle_req, cu_idle;
  logic ru_idle, test_start, test_done, mem_req, mem_ack, ctrl_reset;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_d, got_a, got_d, exp_d;
  logic [15:0] gptr;
  lprs_result_t test_result, fail = 3'h0;
  lprs_memwr_t mem_wr;
  int failures = 0, tests_run = 0;
  lprs_port #(.RST_HOLD(2)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .gptr(gptr),
    .unit_idle_req(unit_idle_req),
    .cu_idle(cu_idle),
    .ru_idle(ru_idle),
    .test_start(test_start),
    .test_done(test_done),
    .test_result(test_result),
    .mem_req(mem_req),
    .mem_wr(mem_wr),
    .mem_ack(mem_ack),
    .ctrl_reset(ctrl_reset)
  );
  lprs_unit_model u_mdl (
    .pclk(pclk),
    .presetn(presetn),
    .unit_idle_req(unit_idle_req),
    .test_start(test_start),
    .mem_req(mem_req),
    .fail(fail),
    .cu_idle(cu_idle),
    .ru_idle(ru_idle),
    .test_done(test_done),
    .test_result(test_result),
    .mem_ack(mem_ack)
  );
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (mem_req && mem_ack) {got_a, got_d} <= mem_wr;
  task wrap_up;
    $display("runs %0d fails %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rd_d, rd_e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'h0, 32'h0, 4'h0);
    chk(rd_d, e);
  endtask
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    apb(12'h004, 1'h1, 32'hFFFFABCD, 4'hF);
    rd(12'h004, 32'h0000ABCD);
    chk({16'h0, gptr}, 32'h0000ABCD);
    $display("end regs");
    apb(12'h008, 1'h1, 32'h00000002, 4'h1);
    apb(12'h008, 1'h1, 32'h00005600, 4'h2);
    apb(12'h008, 1'h1, 32'h00340000, 4'h4);
    chk({31'h0, unit_idle_req}, 32'h0);
    apb(12'h008, 1'h1, 32'h12000000, 4'h8);
    rd(12'h008, 32'h12345602);
    chk({31'h0, unit_idle_req}, 32'h1);
    do apb(12'h008, 1'h0, 32'h0, 4'h0); while (rd_d !== 32'h0);
    rd(12'h004, 32'h0000ABCD);
    $display("end selective");
    for (int c = 3; c < 16; c++)
    begin
      apb(12'h008, 1'h1, {28'h0, c[3:0]}, 4'hF);
      rd(12'h008, {28'h0, c[3:0]});
      chk({31'h0, unit_idle_req | ctrl_reset}, 32'h0);
    end
    $display("end reserved");
    for (int i = 0; i < 8; i++)
    begin
      fail <= i[2:0];
      apb(12'h004, 1'h1, 32'h00001234, 4'hF);
      apb(12'h008, 1'h1, {20'h0ABC0, i[7:0], 4'h1}, 4'hF);
      @(posedge ctrl_reset);
      @(negedge ctrl_reset);
      chk(got_a, {20'h0ABC0, i[7:0], 4'h0});
      exp_d = {19'h0, |i[2:0], 6'h0, i[2], 1'h0, i[1], i[0], 2'h0};
      chk(got_d, exp_d);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h0);
    end
    $display("end selftest");
    apb(12'h004, 1'h1, 32'h00005555, 4'hF);
    apb(12'h008, 1'h1, 32'h00000002, 4'hF);
    @(negedge unit_idle_req);
    apb(12'h008, 1'h1, 32'h00000000, 4'hF);
    @(negedge ctrl_reset);
    repeat (250) @(posedge pclk);
    rd(12'h004, 32'h0);
    chk({16'h0, gptr}, 32'h0);
    rd(12'h010, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    $display("end full reset");
    wrap_up();
  end
endmodule
